// *** dv/dpmh_dev_model.sv ***
// device model: two-port RAM with mailbox flags, contention and semaphores
// assumes the host owns the left port; right-port activity is ordered by the bench
module dpmh_dev_model
  import dpmh_pkg::*;
(
  // left port from the host
  input  wire logic        clk_i,
  input  wire dpmh_pins_t  pins_i,
  input  wire logic [7:0]  hd_i,
  input  wire logic        hd_oe_n_i,
  input  wire logic        hb_i,
  input  wire logic        hb_oe_n_i,
  input  wire logic        slave_i,
  // right-port actions from the bench
  input  wire logic        rwr_i,
  input  wire logic        rsem_i,
  input  wire logic        rd0_i,
  input  wire logic        rhold_i,
  input  wire logic [12:0] raddr_i,
  // resolved wires
  output logic [7:0]       data_o,
  output logic             busy_n_o,
  output logic             lirq_n_o,
  output logic             rirq_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:8191];            // unwritten words read unknown
  logic [7:0] lown = '0, rown = '0;    // token holder per semaphore
  logic [7:0] lreq = '0, rreq = '0;    // pending request per semaphore
  logic [7:0] last = '0, token_q = '1; // bus keeper, semaphore read latch
  wire  [2:0] li = pins_i.addr[2:0];
  wire  [2:0] ri = raddr_i[2:0];
  wire        sel_m = !pins_i.mem_sel_n;
  wire        sel_s = !pins_i.semaphore_select_n;
  wire        rd_on = !pins_i.oe_n && pins_i.rw_n && (sel_m || sel_s);
  wire        wr = !pins_i.rw_n && busy_n_o;
  // only the left side is ever flagged here, so both never go low together
  wire        lbusy_n = !(rhold_i && sel_m && pins_i.addr == raddr_i);
  wire  [3:0] ls = {lown[li], rown[li], lreq[li], rreq[li]};
  wire  [3:0] rs = {rown[ri], lown[ri], rreq[ri], lreq[ri]};
  // host drive wins; in secondary mode the pin is input only
  assign busy_n_o = !hb_oe_n_i ? hb_i : (slave_i || lbusy_n);
  // a released bus shows the inverse of its last value, never a stale copy
  assign data_o = !hd_oe_n_i ? hd_i : rd_on ? (sel_s ? token_q : mem[pins_i.addr]) : ~last;
  // s = {mine, theirs, my request, their request}
  function automatic logic [3:0] token_step(input logic d0, input logic [3:0] s);
    if (!d0)
      return s[2] ? {s[3:2], 1'b1, s[0]} : {1'b1, s[2:0]};
    return s[3] ? {1'b0, s[0], 2'b00} : {s[3:2], 1'b0, s[0]};
  endfunction
  // left flag starts set, right flag clear: the host must clear its own after power-up
  initial begin
    lirq_n_o = 1'b0;
    rirq_n_o = 1'b1;
  end
  always @(posedge clk_i) begin
    last <= data_o;
    if (!(sel_s && !pins_i.oe_n)) token_q <= {8{~lown[li]}};
    if (sel_m && wr) mem[pins_i.addr] <= data_o;
    // rhold_i without rwr_i stands for a far-side read with its output enabled
    if (rhold_i && !rwr_i && !rsem_i && raddr_i == MBX_RIGHT_ADR) rirq_n_o <= 1'b1;
    if (sel_m && wr && pins_i.addr == MBX_RIGHT_ADR) rirq_n_o <= 1'b0;
    if (sel_m && !pins_i.oe_n && busy_n_o && pins_i.addr == MBX_LEFT_ADR) lirq_n_o <= 1'b1;
    if (rwr_i && !rsem_i && raddr_i == MBX_LEFT_ADR) lirq_n_o <= 1'b0;
    if (sel_s && wr) {lown[li], rown[li], lreq[li], rreq[li]} <= token_step(data_o[0], ls);
    if (rwr_i && rsem_i) {rown[ri], lown[ri], rreq[ri], lreq[ri]} <= token_step(rd0_i, rs);
  end
endmodule

// *** dv/tb_dpmh_port_ctrl.sv ***
// self-checking bench: left-port controller against the device model
// assumes a 250 MHz clock; inputs change on the falling edge
module tb_dpmh_port_ctrl
  import dpmh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, cmd_valid, sec, wblk, rwr, rsem, rd0, rhold;
  logic        ready, rsp_valid, rsp_cont, init_done, irq, irq_n, rirq_n, doe_n, cont_n, cont_o, cont_oe_n;
  logic [12:0] raddr;
  logic [7:0]  rsp_data, din, dout;
  dpmh_cmd_t   cmd;
  dpmh_pins_t  pins;
  int          failures = 0;
  int          samples_checked = 0;
  dpmh_port_ctrl DUT (.sys_clk_i(clk), .sys_rst_i(rst), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .cmd_ready_o(ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_contended_o(rsp_cont),
    .init_done_o(init_done), .secondary_mode_i(sec), .write_block_i(wblk), .mbx_irq_n_i(irq_n),
    .mbx_irq_o(irq), .pins_o(pins), .data_i(din), .data_o(dout), .data_oe_n_o(doe_n),
    .contention_n_i(cont_n), .contention_n_o(cont_o), .contention_oe_n_o(cont_oe_n));
  dpmh_dev_model dev (.clk_i(clk), .pins_i(pins), .hd_i(dout), .hd_oe_n_i(doe_n), .hb_i(cont_o),
    .hb_oe_n_i(cont_oe_n), .slave_i(sec), .rwr_i(rwr), .rsem_i(rsem), .rd0_i(rd0), .rhold_i(rhold),
    .raddr_i(raddr), .data_o(din), .busy_n_o(cont_n), .lirq_n_o(irq_n), .rirq_n_o(rirq_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  // offer one command, wait for its response pulse under a bound
  task automatic run(input dpmh_op_t op, input logic [12:0] a, input logic [7:0] d);
    int n = 0;
    @(negedge clk);
    cmd = '{op, a, d};
    cmd_valid = 1'b1;
    while (!ready && n < 99) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    while (!rsp_valid && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(rsp_valid, 1'b1, "response pulse");
  endtask
  // one-cycle right-port write, mailbox or semaphore
  task automatic rem(input logic s, input logic [12:0] a, input logic d);
    @(negedge clk);
    {rsem, raddr, rd0} = {s, a, d};
    rwr = 1'b1;
    @(negedge clk);
    rwr = 1'b0;
  endtask
  task automatic t_init;
    int n = 0;
    chk(irq, 1'b1, "flag set at power-up");
    while (!init_done && n < 99) begin
      @(negedge clk);
      n++;
    end
    chk(irq, 1'b0, "flag cleared by init read");
    $display("t_init done");
  endtask
  task automatic t_mbx;
    run(DPMH_OP_WRITE, 13'h1FFF, 8'h5A);
    chk(rirq_n, 1'b0, "far flag raised");
    raddr = 13'h1FFF;
    rhold = 1'b1;
    @(negedge clk);
    rhold = 1'b0;
    chk(rirq_n, 1'b1, "far flag cleared by far read");
    run(DPMH_OP_READ, 13'h1FFF, 8'h00);
    chk(rsp_data, 8'h5A, "mailbox word stores data");
    rem(1'b0, 13'h1FFE, 1'b0);
    chk(irq, 1'b1, "own flag raised");
    run(DPMH_OP_READ, 13'h1FFE, 8'h00);
    chk(irq, 1'b0, "own flag cleared");
    $display("t_mbx done");
  endtask
  task automatic t_sem;
    run(DPMH_OP_SEMWR, 13'h0003, 8'hFE);
    run(DPMH_OP_SEMRD, 13'h0003, 8'h00);
    chk(rsp_data, 8'h00, "token granted");
    run(DPMH_OP_SEMRD, 13'h0004, 8'h00);
    chk(rsp_data, 8'hFF, "other latch free");
    rem(1'b1, 13'h0003, 1'b0);
    run(DPMH_OP_SEMRD, 13'h0003, 8'h00);
    chk(rsp_data, 8'h00, "far request only pending");
    run(DPMH_OP_SEMWR, 13'h0003, 8'h01);
    run(DPMH_OP_SEMWR, 13'h0003, 8'h00);
    run(DPMH_OP_SEMRD, 13'h0003, 8'h00);
    chk(rsp_data, 8'hFF, "token passed to far side");
    rem(1'b1, 13'h0003, 1'b1);
    run(DPMH_OP_SEMRD, 13'h0003, 8'h00);
    chk(rsp_data, 8'h00, "token passed back");
    run(DPMH_OP_SEMWR, 13'h0003, 8'hFF);
    run(DPMH_OP_SEMWR, 13'h0003, 8'h00);
    run(DPMH_OP_SEMRD, 13'h0003, 8'h00);
    chk(rsp_data, 8'h00, "freed then regranted");
    $display("t_sem done");
  endtask
  task automatic t_busy;
    run(DPMH_OP_WRITE, 13'h0010, 8'h3C);
    raddr = 13'h0010;
    rhold = 1'b1;
    fork
      run(DPMH_OP_WRITE, 13'h0010, 8'hA5);
      begin
        repeat (15) @(negedge clk);
        chk(cont_n, 1'b0, "contention on match");
        chk(dev.mem[13'h0010], 8'h3C, "write held off");
        rhold = 1'b0;
      end
    join
    chk(rsp_cont, 1'b1, "contention flagged");
    run(DPMH_OP_READ, 13'h0010, 8'h00);
    chk(rsp_data, 8'hA5, "write lands after release");
    raddr = 13'h0011;
    rhold = 1'b1;
    run(DPMH_OP_WRITE, 13'h0010, 8'h66);
    chk(rsp_cont, 1'b0, "no contention on other address");
    rhold = 1'b0;
    $display("t_busy done");
  endtask
  task automatic t_slave;
    sec = 1'b1;
    wblk = 1'b1;
    run(DPMH_OP_READ, 13'h0010, 8'h00);
    chk({cont_oe_n, cont_o, rsp_cont}, 3'b001, "host blocks port");
    sec = 1'b0;
    wblk = 1'b0;
    @(negedge clk);
    chk(cont_oe_n, 1'b1, "pins released in primary");
    $display("t_slave done");
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // whole run is a few hundred cycles; this cuts a hang
  initial begin
    #100000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up;
  end
  initial begin
    {rst, cmd_valid, sec, wblk, rwr, rsem, rd0, rhold, raddr, cmd} = {1'b1, 20'h0, 23'h0};
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_init;
    t_mbx;
    t_sem;
    t_busy;
    t_slave;
    wrap_up;
  end
endmodule

// *** rtl/dpmh_pkg.sv ***
// package for the two-port mailbox/semaphore port controller
// assumes one 250 MHz clock; device pins are sampled as synchronous inputs
package dpmh_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS     = 4;    // period of sys_clk_i
  localparam int T_APS_NS   = 5;    // arbitration set-up before a strobe
  localparam int T_WH_NS    = 25;   // write hold after contention clears
  localparam int APS_CYC    = (T_APS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WH_CYC     = (T_WH_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_LIMIT = 20;   // cycles within which mailbox init starts

  // ----------------------------------------------------------------
  // address map of the device
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 13;
  localparam int          DATA_W       = 8;
  localparam logic [12:0] MBX_LEFT_ADR = 13'h1FFE;  // left reads, right writes
  localparam logic [12:0] MBX_RIGHT_ADR = 13'h1FFF; // right reads, left writes

  // ----------------------------------------------------------------
  // user command and device pin bundles
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DPMH_OP_READ  = 2'h0,
    DPMH_OP_WRITE = 2'h1,
    DPMH_OP_SEMRD = 2'h2,
    DPMH_OP_SEMWR = 2'h3
  } dpmh_op_t;

  typedef struct packed {
    dpmh_op_t    op;
    logic [12:0] addr;
    logic [7:0]  data;
  } dpmh_cmd_t;

  typedef struct packed {
    logic [12:0] addr;
    logic        mem_sel_n;           // memory array select
    logic        semaphore_select_n;  // semaphore space select
    logic        rw_n;                // low = write
    logic        oe_n;                // output enable
  } dpmh_pins_t;

  localparam dpmh_pins_t PINS_IDLE = '{addr: 13'h0000, mem_sel_n: 1'b1,
                                       semaphore_select_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1};

endpackage

// *** rtl/dpmh_port_ctrl.sv ***
// controller for one port of a two-port mailbox/semaphore RAM
// assumes the device pins sit on the same 250 MHz clock domain and that the
// board resolves the two-way data and contention pins from the enables

// Notes on behaviour
// - host clears mailbox flags after power-up
// - host holds contention inputs high normally
// - stacked contention signals combine by AND
// - semaphore access: memory deselected, semaphore selected
module dpmh_port_ctrl
  import dpmh_pkg::*;
#(
  parameter bit LEFT_SIDE = 1'b1,  // which device port this controller drives
  parameter int N_STACK   = 1,     // devices stacked in depth
  parameter int ACCESS_NS = 70     // strobe width covering device access time
) (
  // clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               sys_rst_i,
  // user command side
  input  wire logic               cmd_valid_i,
  input  wire dpmh_cmd_t          cmd_i,
  output logic                    cmd_ready_o,
  output logic                    rsp_valid_o,
  output logic [7:0]              rsp_data_o,
  output logic                    rsp_contended_o,
  output logic                    init_done_o,
  // mode and write blocking
  input  wire logic               secondary_mode_i,
  input  wire logic               write_block_i,
  // mailbox flag of this port
  input  wire logic               mbx_irq_n_i,
  output logic                    mbx_irq_o,
  // device control pins
  output dpmh_pins_t              pins_o,
  // data bus, two-way
  input  wire logic [7:0]         data_i,
  output logic [7:0]              data_o,
  output logic                    data_oe_n_o,
  // contention pins of all stacked devices, two-way
  input  wire logic [N_STACK-1:0] contention_n_i,
  output logic [N_STACK-1:0]      contention_n_o,
  output logic                    contention_oe_n_o
);

  // ----------------------------------------------------------------
  // elaboration checks and derived counts
  // ----------------------------------------------------------------
  localparam int ACC_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;

  // refused at elaboration: N_STACK outside 1..16, or an access count the 8-bit phase timer cannot hold
  if (N_STACK < 1 || N_STACK > 16) begin : g_bad_stack
    $error("N_STACK out of range");
  end
  if (ACC_CYC < 1 || ACC_CYC > 255) begin : g_bad_access
    $error("ACCESS_NS out of range");
  end

  localparam logic [12:0] MBX_OWN = LEFT_SIDE ? MBX_LEFT_ADR : MBX_RIGHT_ADR;

  typedef enum logic [1:0] {
    DPMH_IDLE   = 2'b00,
    DPMH_SETUP  = 2'b01,
    DPMH_STROBE = 2'b11,
    DPMH_HOLD   = 2'b10
  } dpmh_state_t;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dpmh_state_t state;       // access sequencer
  dpmh_cmd_t   cur;         // command in flight
  logic        init_pend;   // mailbox clear still owed after reset
  logic        init_run;    // current access is the internal clear
  logic [7:0]  cnt;         // phase timer
  logic        contended;   // contention seen during this access

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire is_token = cur.op[1];
  wire is_write = cur.op[0];
  // stacked devices each flag the losing port; any low one blocks
  wire busy_any = ~(&contention_n_i);

  assign cmd_ready_o = (state == DPMH_IDLE) && !init_pend;
  assign mbx_irq_o   = ~mbx_irq_n_i;

  // secondary mode: host drives the inhibit pins, high unless blocking
  assign contention_oe_n_o = ~secondary_mode_i;
  assign contention_n_o    = {N_STACK{~write_block_i}};

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state           <= DPMH_IDLE;
      cur             <= '{op: DPMH_OP_READ, addr: 13'h0000, data: 8'h00};
      init_pend       <= 1'b1;
      init_run        <= 1'b0;
      cnt             <= 8'h00;
      contended       <= 1'b0;
      pins_o          <= PINS_IDLE;
      data_o          <= 8'h00;
      data_oe_n_o     <= 1'b1;
      rsp_valid_o     <= 1'b0;
      rsp_data_o      <= 8'h00;
      rsp_contended_o <= 1'b0;
      init_done_o     <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      unique case (state)
        // wait for the owed mailbox clear, then for user commands
        DPMH_IDLE: begin
          if (init_pend) begin
            // read own mailbox: clears this port's flag to a known state
            cur       <= '{op: DPMH_OP_READ, addr: MBX_OWN, data: 8'h00};
            init_pend <= 1'b0;
            init_run  <= 1'b1;
            state     <= DPMH_SETUP;
            cnt       <= 8'(APS_CYC);
          end else if (cmd_valid_i) begin
            cur      <= cmd_i;
            init_run <= 1'b0;
            state    <= DPMH_SETUP;
            cnt      <= 8'(APS_CYC);
          end
        end
        // address and select settle before any strobe so arbitration resolves
        DPMH_SETUP: begin
          pins_o.addr               <= cur.addr;
          pins_o.mem_sel_n          <= is_token;
          pins_o.semaphore_select_n <= ~is_token;
          contended                 <= 1'b0;
          if (is_write) begin
            // semaphore writes only use bit 0; spread it for a clean bus
            data_o      <= is_token ? {8{cur.data[0]}} : cur.data;
            data_oe_n_o <= 1'b0;
          end
          if (cnt == 8'h00) begin
            state       <= DPMH_STROBE;
            cnt         <= 8'(ACC_CYC);
            pins_o.rw_n <= ~is_write;
            pins_o.oe_n <= is_write;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        // strobe; a write under contention is held until it clears plus hold
        DPMH_STROBE: begin
          if (is_write && busy_any) begin
            cnt       <= 8'(WH_CYC);
            contended <= 1'b1;
          end else if (cnt == 8'h00) begin
            rsp_data_o  <= data_i;
            pins_o.rw_n <= 1'b1;
            pins_o.oe_n <= 1'b1;
            state       <= DPMH_HOLD;
          end else begin
            cnt <= cnt - 8'h01;
          end
          if (!is_write && busy_any) begin
            contended <= 1'b1;
          end
        end
        // drop selects so a repeated semaphore read sees a fresh latch
        DPMH_HOLD: begin
          pins_o.mem_sel_n          <= 1'b1;
          pins_o.semaphore_select_n <= 1'b1;
          data_oe_n_o               <= 1'b1;
          rsp_valid_o               <= !init_run;
          rsp_contended_o           <= contended;
          if (init_run) begin
            init_done_o <= 1'b1;
          end
          state <= DPMH_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_token_select_excl: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !pins_o.semaphore_select_n |-> pins_o.mem_sel_n)
    else $error("semaphore select with memory selected");

  a_init_mbx_read: assert property (@(posedge sys_clk_i)
    $fell(sys_rst_i) |-> ##[1:20] (!pins_o.oe_n && !pins_o.mem_sel_n && pins_o.addr == MBX_OWN))
    else $error("mailbox flag not cleared after reset");

  a_busy_hold_high: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (secondary_mode_i && !write_block_i) |-> (!contention_oe_n_o && &contention_n_o))
    else $error("contention inputs not held high");

  a_write_held_busy: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (state == DPMH_STROBE && is_write && !contention_n_i[N_STACK-1]) |=> !pins_o.rw_n [*2])
    else $error("write strobe ended under contention");

  a_mbx_write_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (state == DPMH_STROBE && is_write && busy_any) ##1 !busy_any |-> !pins_o.rw_n [*7])
    else $error("write hold after contention too short");

  a_token_sel_release: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (state == DPMH_HOLD) |=> (pins_o.semaphore_select_n && pins_o.oe_n && state == DPMH_IDLE))
    else $error("selects not released after access");

endmodule
